/* File: inc/gating_pkg.sv */
// shared constants, types and register map of the control-pin gating block
package gating_pkg;

  // -------------------------------------------------------------------------
  // widths
  // -------------------------------------------------------------------------
  localparam int CHANNELS = 8;
  localparam int INPUTS = 2;
  localparam int PWM_GENS = 2;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int DUTY_W = 8;

  // -------------------------------------------------------------------------
  // register byte offsets
  // -------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_OUTPUT = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_INPUT_A_CHANNEL_MAP = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_INPUT_B_CHANNEL_MAP = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PWM0_CFG = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_PWM1_CFG = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_PWM0_MAP = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_PWM1_MAP = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_INPUT_LEVEL_MONITOR = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h20;

  // -------------------------------------------------------------------------
  // reset values and field positions
  // -------------------------------------------------------------------------
  localparam logic [CHANNELS-1:0] RST_OUTPUT = 8'h00;
  localparam logic [CHANNELS-1:0] RST_INPUT_A_CHANNEL_MAP = 8'h04;
  localparam logic [CHANNELS-1:0] RST_INPUT_B_CHANNEL_MAP = 8'h08;
  localparam logic [CHANNELS-1:0] RST_PWM_MAP = 8'h00;
  localparam logic [DUTY_W-1:0] RST_PWM_DUTY = 8'h00;
  localparam int PWM_EN_BIT = 8;
  localparam int STATUS_MODE_LSB = 0;
  localparam int STATUS_VS_UV_BIT = 4;
  localparam int STATUS_VS_LOW_BIT = 5;
  localparam int STATUS_VDD_UV_BIT = 6;
  localparam int STATUS_SERIAL_OK_BIT = 7;

  // -------------------------------------------------------------------------
  // types
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SLEEP,
    MODE_IDLE,
    MODE_ACTIVE,
    MODE_FAIL_SAFE
  } op_mode_t;

  typedef struct packed {
    logic vs_uv;
    logic vs_below_op;
    logic vdd_uv;
  } supply_state_t;

  typedef struct packed {
    logic enable;
    logic [DUTY_W-1:0] duty;
  } pwm_cfg_t;

  typedef struct packed {
    logic idle_req_high;
    logic direct_input_b;
    logic direct_input_a;
  } pin_set_t;

endpackage

/* File: src/pin_sync.sv */
// two-flop synchroniser for the control pins
`timescale 1ns/1ps
module pin_sync
  import gating_pkg::*;
#(
  parameter int WIDTH = 3
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // pins
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          meta[g] <= 1'b0;
          sync_out[g] <= 1'b0;
        end else if (clk_en) begin
          meta[g] <= async_in[g];
          sync_out[g] <= meta[g];
        end
      end
    end
  endgenerate

endmodule // pin_sync

/* File: src/pwm_gen.sv */
// free-running pwm generator, output high while count is below duty
`timescale 1ns/1ps
module pwm_gen
  import gating_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // configuration
  input wire pwm_cfg_t cfg,
  // output
  output logic pwm_out
);

  logic [DUTY_W-1:0] count;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (clk_en) begin
      count <= count + 8'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_out <= 1'b0;
    end else if (clk_en) begin
      pwm_out <= cfg.enable && (count < cfg.duty);
    end
  end

endmodule // pwm_gen

/* File: src/pin_mode_gating.sv */
// control-pin routing, operating mode and supply gating of an eight-channel switch
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module pin_mode_gating
  import gating_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // control pins
  input wire logic direct_input_a,
  input wire logic direct_input_b,
  input wire logic idle_req_high,
  // supply detector flags
  input wire supply_state_t supply,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // channel and supply control
  output logic [CHANNELS-1:0] channel_drive,
  output logic uv_detect_enable,
  output logic serial_out_enable,
  output op_mode_t mode
);

  // -------------------------------------------------------------------------
  // pin synchronisation
  // -------------------------------------------------------------------------
  pin_set_t pins_raw;
  pin_set_t pins;

  assign pins_raw = '{idle_req_high: idle_req_high, direct_input_b: direct_input_b,
                      direct_input_a: direct_input_a};

  pin_sync #(.WIDTH(3)) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .async_in(pins_raw),
    .sync_out(pins)
  );

  // -------------------------------------------------------------------------
  // conditions derived from pins and supplies
  // -------------------------------------------------------------------------
  logic any_input;
  logic sleep_cond;
  logic fail_safe_cond;
  logic regs_clear;
  logic serial_blocked;

  assign any_input = pins.direct_input_a | pins.direct_input_b;
  assign sleep_cond = !pins.idle_req_high && !any_input;
  assign fail_safe_cond = !pins.idle_req_high && any_input;
  // low-power request or logic undervoltage wipes the register file
  assign regs_clear = !pins.idle_req_high || supply.vdd_uv;
  // in sleep the serial port is dead; undervoltage of the logic supply too
  assign serial_blocked = sleep_cond || supply.vdd_uv;

  // -------------------------------------------------------------------------
  // register file
  // -------------------------------------------------------------------------
  logic [CHANNELS-1:0] output_reg;
  logic [CHANNELS-1:0] input_a_channel_map;
  logic [CHANNELS-1:0] input_b_channel_map;
  pwm_cfg_t pwm_cfg [PWM_GENS];
  logic [CHANNELS-1:0] pwm_map [PWM_GENS];

  logic access;
  logic wr_en;
  logic addr_hit;
  logic [DATA_W-1:0] next_rdata;

  // answer one cycle into the access phase
  assign access = psel && penable && !pready;
  assign wr_en = psel && penable && pready && pwrite && !pslverr;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      output_reg <= RST_OUTPUT;
    end else if (clk_en) begin
      if (regs_clear) begin
        output_reg <= RST_OUTPUT;
      end else if (wr_en && paddr == OFS_OUTPUT) begin
        output_reg <= pwdata[CHANNELS-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      input_a_channel_map <= RST_INPUT_A_CHANNEL_MAP;
      input_b_channel_map <= RST_INPUT_B_CHANNEL_MAP;
    end else if (clk_en) begin
      if (regs_clear) begin
        input_a_channel_map <= RST_INPUT_A_CHANNEL_MAP;
        input_b_channel_map <= RST_INPUT_B_CHANNEL_MAP;
      end else if (wr_en && paddr == OFS_INPUT_A_CHANNEL_MAP) begin
        input_a_channel_map <= pwdata[CHANNELS-1:0];
      end else if (wr_en && paddr == OFS_INPUT_B_CHANNEL_MAP) begin
        input_b_channel_map <= pwdata[CHANNELS-1:0];
      end
    end
  end

  logic [PWM_GENS-1:0] pwm_level;

  genvar g;
  generate
    for (g = 0; g < PWM_GENS; g++) begin : g_pwm
      localparam logic [ADDR_W-1:0] CFG_OFS = (g == 0) ? OFS_PWM0_CFG : OFS_PWM1_CFG;
      localparam logic [ADDR_W-1:0] MAP_OFS = (g == 0) ? OFS_PWM0_MAP : OFS_PWM1_MAP;

      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          pwm_cfg[g] <= '{enable: 1'b0, duty: RST_PWM_DUTY};
          pwm_map[g] <= RST_PWM_MAP;
        end else if (clk_en) begin
          if (regs_clear) begin
            pwm_cfg[g] <= '{enable: 1'b0, duty: RST_PWM_DUTY};
            pwm_map[g] <= RST_PWM_MAP;
          end else if (wr_en && paddr == CFG_OFS) begin
            pwm_cfg[g] <= '{enable: pwdata[PWM_EN_BIT], duty: pwdata[DUTY_W-1:0]};
          end else if (wr_en && paddr == MAP_OFS) begin
            pwm_map[g] <= pwdata[CHANNELS-1:0];
          end
        end
      end

      pwm_gen u_pwm (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .cfg(pwm_cfg[g]),
        .pwm_out(pwm_level[g])
      );
    end
  endgenerate

  // -------------------------------------------------------------------------
  // apb answer
  // -------------------------------------------------------------------------
  always_comb begin
    next_rdata = '0;
    addr_hit = 1'b1;
    unique case (paddr)
      OFS_OUTPUT: next_rdata[CHANNELS-1:0] = output_reg;
      OFS_INPUT_A_CHANNEL_MAP: next_rdata[CHANNELS-1:0] = input_a_channel_map;
      OFS_INPUT_B_CHANNEL_MAP: next_rdata[CHANNELS-1:0] = input_b_channel_map;
      OFS_PWM0_CFG: next_rdata[PWM_EN_BIT:0] = pwm_cfg[0];
      OFS_PWM1_CFG: next_rdata[PWM_EN_BIT:0] = pwm_cfg[1];
      OFS_PWM0_MAP: next_rdata[CHANNELS-1:0] = pwm_map[0];
      OFS_PWM1_MAP: next_rdata[CHANNELS-1:0] = pwm_map[1];
      // monitor follows the pins in idle, active and fail-safe; reads in sleep are refused
      OFS_INPUT_LEVEL_MONITOR: next_rdata[INPUTS-1:0] = {pins.direct_input_b, pins.direct_input_a};
      OFS_STATUS: begin
        next_rdata[STATUS_MODE_LSB +: 2] = mode;
        next_rdata[STATUS_VS_UV_BIT] = supply.vs_uv;
        next_rdata[STATUS_VS_LOW_BIT] = supply.vs_below_op;
        next_rdata[STATUS_VDD_UV_BIT] = supply.vdd_uv;
        next_rdata[STATUS_SERIAL_OK_BIT] = serial_out_enable;
      end
      default: addr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (clk_en) begin
      pready <= access;
      if (access) begin
        // refused transfers still complete so the master is never hung
        pslverr <= serial_blocked || !addr_hit || (pwrite && paddr == OFS_INPUT_LEVEL_MONITOR)
                   || (pwrite && paddr == OFS_STATUS);
        prdata <= (serial_blocked || pwrite) ? '0 : next_rdata;
      end else begin
        pslverr <= 1'b0;
        prdata <= '0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_out_enable <= 1'b0;
    end else if (clk_en) begin
      serial_out_enable <= !serial_blocked;
    end
  end

  // -------------------------------------------------------------------------
  // channel request
  // -------------------------------------------------------------------------
  logic [CHANNELS-1:0] input_req;
  logic [CHANNELS-1:0] pwm_req;
  logic [CHANNELS-1:0] request;
  logic [CHANNELS-1:0] default_req;

  always_comb begin
    input_req = ({CHANNELS{pins.direct_input_a}} & input_a_channel_map)
              | ({CHANNELS{pins.direct_input_b}} & input_b_channel_map);
    pwm_req = ({CHANNELS{pwm_level[0]}} & pwm_map[0])
            | ({CHANNELS{pwm_level[1]}} & pwm_map[1]);
    request = output_reg | pwm_req | input_req;
    // fail-safe ignores programmed maps and uses the default routing
    default_req = ({CHANNELS{pins.direct_input_a}} & RST_INPUT_A_CHANNEL_MAP)
                | ({CHANNELS{pins.direct_input_b}} & RST_INPUT_B_CHANNEL_MAP);
  end

  // -------------------------------------------------------------------------
  // operating mode
  // -------------------------------------------------------------------------
  op_mode_t next_mode;
  logic any_request;

  assign any_request = (|output_reg) || pwm_cfg[0].enable || pwm_cfg[1].enable || (|input_req);

  always_comb begin
    next_mode = mode;
    if (fail_safe_cond) begin
      next_mode = MODE_FAIL_SAFE;
    end else if (sleep_cond) begin
      next_mode = MODE_SLEEP;
    end else begin
      unique case (mode)
        MODE_SLEEP: next_mode = MODE_IDLE;
        MODE_FAIL_SAFE: next_mode = MODE_IDLE;
        MODE_IDLE: begin
          if (any_request) begin
            next_mode = MODE_ACTIVE;
          end
        end
        MODE_ACTIVE: begin
          if (!any_request) begin
            next_mode = MODE_IDLE;
          end
        end
      endcase
    end
  end

  // pin holds are the host's duty; a shorter pulse just yields a short mode
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= MODE_SLEEP;
    end else if (clk_en) begin
      mode <= next_mode;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      uv_detect_enable <= 1'b0;
    end else if (clk_en) begin
      uv_detect_enable <= !sleep_cond;
    end
  end

  // -------------------------------------------------------------------------
  // channel drive with supply gating
  // -------------------------------------------------------------------------
  logic [CHANNELS-1:0] next_drive;

  always_comb begin
    unique case (mode)
      MODE_ACTIVE: next_drive = request;
      MODE_FAIL_SAFE: next_drive = default_req;
      default: next_drive = '0;
    endcase
    if (supply.vs_uv) begin
      next_drive = '0;
    end else if (supply.vs_below_op) begin
      // weak battery: may not switch on, but never forces off
      next_drive = next_drive & channel_drive;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_drive <= '0;
    end else if (clk_en) begin
      channel_drive <= next_drive;
    end
  end

endmodule // pin_mode_gating

/* File: verif/host_pins.sv */
// host model that drives the three control pins
`timescale 1ns/1ps
module host_pins #(
  parameter int HOLD = 4
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // levels the bench asks for
  input wire logic want_idle,
  input wire logic want_a,
  input wire logic want_b,
  // pins
  output logic idle_req_high,
  output logic direct_input_a,
  output logic direct_input_b
);
  int held;
  // --------------------------------------------------------------
  // a new low-power level is only taken once the old one has stood
  // --------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_req_high <= 1'b0;
      direct_input_a <= 1'b0;
      direct_input_b <= 1'b0;
      held <= 0;
    end else begin
      direct_input_a <= want_a;
      direct_input_b <= want_b;
      if (want_idle != idle_req_high && held >= HOLD) begin
        idle_req_high <= want_idle;
        held <= 0;
      end else if (held < HOLD) begin
        held <= held + 1;
      end
    end
  end
endmodule // host_pins

/* File: verif/gating_monitor.sv */
// assertion checker for the control-pin gating block
`timescale 1ns/1ps
module gating_monitor
  import gating_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // pins and supplies
  input wire logic direct_input_a,
  input wire logic direct_input_b,
  input wire logic idle_req_high,
  input wire supply_state_t supply,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // outputs
  input wire logic [CHANNELS-1:0] channel_drive,
  input wire logic uv_detect_enable,
  input wire logic serial_out_enable,
  input wire op_mode_t mode
);
  // --------------------------------------------------------------
  // pin sequences, long enough to pass the synchroniser and mode flop
  // --------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence access_s;
    psel && penable && !pready;
  endsequence
  sequence sleep_s;
    (!idle_req_high && !direct_input_a && !direct_input_b)[*5];
  endsequence
  sequence safe_s;
    (!idle_req_high && (direct_input_a || direct_input_b) && supply == '0)[*6];
  endsequence

  a_sleep_mode: assert property (sleep_s |-> mode == MODE_SLEEP)
    else $error("sleep not entered");
  a_safe_mode: assert property (safe_s |-> mode == MODE_FAIL_SAFE)
    else $error("fail-safe not entered");
  a_safe_default: assert property (safe_s ##1 supply == '0 |-> (channel_drive & 8'hf3) == '0)
    else $error("fail-safe drives a non-default channel");
  a_detect_off: assert property (sleep_s |-> !uv_detect_enable)
    else $error("detectors on in sleep");
  a_serial_hiz: assert property (sleep_s |-> !serial_out_enable)
    else $error("serial output enabled in sleep");
  a_sleep_refuse: assert property (sleep_s ##0 access_s |=> pready && pslverr && prdata == '0)
    else $error("access not refused in sleep");
  a_vdd_refuse: assert property ((supply.vdd_uv ##0 access_s) |=> pready && pslverr)
    else $error("access not refused in logic undervoltage");
  a_vs_uv_off: assert property (supply.vs_uv |=> channel_drive == '0)
    else $error("channel on in battery undervoltage");
  a_no_new_on: assert property (supply.vs_below_op && !supply.vs_uv |=> (channel_drive & ~$past(channel_drive)) == '0)
    else $error("channel turned on below operating threshold");
endmodule // gating_monitor

bind pin_mode_gating gating_monitor mon_u (.sys_clk(sys_clk), .rst_n(rst_n), .direct_input_a(direct_input_a),
  .direct_input_b(direct_input_b), .idle_req_high(idle_req_high), .supply(supply), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .channel_drive(channel_drive),
  .uv_detect_enable(uv_detect_enable), .serial_out_enable(serial_out_enable), .mode(mode));

/* File: verif/tb.sv */
// self-checking bench of the control-pin gating block
`timescale 1ns/1ps
module tb import gating_pkg::*;;
  logic sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic want_idle = 0, want_a = 0, want_b = 0, idle_req_high, direct_input_a, direct_input_b;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0, prdata;
  logic pready, pslverr, uv_detect_enable, serial_out_enable;
  logic [CHANNELS-1:0] channel_drive;
  supply_state_t supply = '0;
  op_mode_t mode;
  int failures = 0, num_checks = 0;

  always #12.5 sys_clk = ~sys_clk;

  host_pins host_u (.sys_clk(sys_clk), .rst_n(rst_n), .want_idle(want_idle), .want_a(want_a),
    .want_b(want_b), .idle_req_high(idle_req_high), .direct_input_a(direct_input_a),
    .direct_input_b(direct_input_b));
  pin_mode_gating dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(1'b1), .direct_input_a(direct_input_a),
    .direct_input_b(direct_input_b), .idle_req_high(idle_req_high), .supply(supply), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .channel_drive(channel_drive), .uv_detect_enable(uv_detect_enable),
    .serial_out_enable(serial_out_enable), .mode(mode));

  // --------------------------------------------------------------
  // helpers, all entered just after a rising edge
  // --------------------------------------------------------------
  task chk(input logic [DATA_W:0] got, input logic [DATA_W:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task final_report;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // x is {error, read data}; writes expect zero data
  task rw(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [DATA_W:0] x);
    logic [DATA_W-1:0] r;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk) penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = w ? '0 : prdata;
    chk({pslverr, r}, x);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task pins(input logic i, input logic a, input logic b);
    want_idle <= i;
    want_a <= a;
    want_b <= b;
    @(posedge sys_clk);
  endtask
  task wmode(input op_mode_t m);
    for (int n = 0; n < 40 && mode !== m; n++) @(posedge sys_clk);
    chk(mode, m);
    repeat (3) @(posedge sys_clk);
  endtask
  task hold(input logic [CHANNELS-1:0] d);
    // host flop, two sync flops and the drive flop lie between a pin request and the channel
    repeat (4) @(posedge sys_clk);
    chk(channel_drive, d);
  endtask

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task s_boot;
    wmode(MODE_SLEEP);
    chk(uv_detect_enable, 1'b0);
    chk(serial_out_enable, 1'b0);
    rw(1'b0, OFS_OUTPUT, '0, {1'b1, 32'h0});
  endtask
  task s_map;
    pins(1'b1, 1'b0, 1'b0);
    wmode(MODE_IDLE);
    rw(1'b0, OFS_INPUT_A_CHANNEL_MAP, '0, {1'b0, 32'h4});
    rw(1'b0, OFS_INPUT_B_CHANNEL_MAP, '0, {1'b0, 32'h8});
    rw(1'b1, OFS_INPUT_LEVEL_MONITOR, 32'h3, {1'b1, 32'h0});
    rw(1'b0, 8'h40, '0, {1'b1, 32'h0});
    pins(1'b1, 1'b1, 1'b0);
    wmode(MODE_ACTIVE);
    chk(channel_drive, 8'h04);
    chk(serial_out_enable, 1'b1);
    rw(1'b0, OFS_STATUS, '0, {1'b0, 32'h82});
    rw(1'b0, OFS_INPUT_LEVEL_MONITOR, '0, {1'b0, 32'h1});
    rw(1'b1, OFS_INPUT_A_CHANNEL_MAP, 32'h81, {1'b0, 32'h0});
    rw(1'b1, OFS_OUTPUT, 32'h10, {1'b0, 32'h0});
    hold(8'h91);
    pins(1'b1, 1'b1, 1'b1);
    hold(8'h99);
    // pwm 0 onto channel 5 at half duty: channel must rise and then fall, each within 300 cycles
    rw(1'b1, OFS_PWM0_MAP, 32'h20, {1'b0, 32'h0});
    rw(1'b1, OFS_PWM0_CFG, 32'h180, {1'b0, 32'h0});
    rw(1'b0, OFS_PWM0_CFG, '0, {1'b0, 32'h180});
    for (int n = 0; n < 300 && channel_drive[5] !== 1'b1; n++) @(posedge sys_clk);
    chk(channel_drive, 8'hb9);
    for (int n = 0; n < 300 && channel_drive[5] !== 1'b0; n++) @(posedge sys_clk);
    chk(channel_drive, 8'h99);
  endtask
  task s_safe;
    pins(1'b0, 1'b1, 1'b0);
    wmode(MODE_FAIL_SAFE);
    chk(channel_drive, 8'h04);
    chk(uv_detect_enable, 1'b1);
    chk(serial_out_enable, 1'b1);
    rw(1'b0, OFS_INPUT_LEVEL_MONITOR, '0, {1'b0, 32'h1});
    rw(1'b0, OFS_INPUT_A_CHANNEL_MAP, '0, {1'b0, 32'h4});
    rw(1'b0, OFS_OUTPUT, '0, {1'b0, 32'h0});
    pins(1'b0, 1'b0, 1'b0);
    wmode(MODE_SLEEP);
    chk(uv_detect_enable, 1'b0);
    rw(1'b0, OFS_INPUT_LEVEL_MONITOR, '0, {1'b1, 32'h0});
  endtask
  task s_supply;
    pins(1'b1, 1'b0, 1'b0);
    wmode(MODE_IDLE);
    rw(1'b1, OFS_OUTPUT, 32'h1, {1'b0, 32'h0});
    wmode(MODE_ACTIVE);
    hold(8'h01);
    supply.vs_below_op <= 1'b1;
    rw(1'b1, OFS_OUTPUT, 32'h3, {1'b0, 32'h0});
    hold(8'h01);
    supply.vs_below_op <= 1'b0;
    hold(8'h03);
    supply.vs_uv <= 1'b1;
    hold(8'h00);
    supply.vs_uv <= 1'b0;
    hold(8'h03);
    supply.vdd_uv <= 1'b1;
    rw(1'b1, OFS_OUTPUT, 32'h7, {1'b1, 32'h0});
    supply.vdd_uv <= 1'b0;
    rw(1'b0, OFS_OUTPUT, '0, {1'b0, 32'h0});
    rw(1'b1, OFS_OUTPUT, 32'h1, {1'b0, 32'h0});
    wmode(MODE_ACTIVE);
    supply <= 3'b101;
    rw(1'b0, OFS_OUTPUT, '0, {1'b1, 32'h0});
    chk(channel_drive, 8'h00);
    supply <= '0;
  endtask

  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    s_boot;
    s_map;
    s_safe;
    s_supply;
    final_report;
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    failures++;
    final_report;
  end
endmodule // tb
